// File: src/asc_pkg.sv
package asc_pkg;

	// ****************************************************************
	// Bus address and control word layout.
	// ****************************************************************
	localparam logic [6:0] ASC_BUS_ADDR = 7'h31;
	localparam int ASC_WORD_BITS = 16;
	localparam int ASC_ADDR_MSB = 15;
	localparam int ASC_ADDR_LSB = 9;
	localparam int ASC_DATA_MSB = 7;

	// ****************************************************************
	// Register offsets.
	// ****************************************************************
	localparam logic [6:0] OFS_LEFT_GAIN = 7'h00;
	localparam logic [6:0] OFS_RIGHT_GAIN = 7'h01;
	localparam logic [6:0] OFS_MODE = 7'h02;
	localparam logic [6:0] OFS_LVL_TIMING = 7'h03;
	localparam logic [6:0] OFS_LVL_CONFIG = 7'h04;
	localparam logic [6:0] OFS_SHUTDOWN = 7'h05;
	localparam logic [6:0] OFS_FAULT = 7'h06;
	localparam logic [6:0] OFS_FAULT_CLEAR = 7'h07;
	localparam logic [6:0] OFS_SOFT_RESET = 7'h08;

	// ****************************************************************
	// Reset values and writable bit masks.
	// ****************************************************************
	localparam logic [7:0] RST_GAIN = 8'h22;
	localparam logic [7:0] RST_MODE = 8'h0c;
	localparam logic [7:0] RST_LVL_TIMING = 8'h2b;
	localparam logic [7:0] RST_LVL_CONFIG = 8'h4b;
	localparam logic [7:0] RST_SHUTDOWN = 8'h03;
	localparam logic [3:0] RST_FAULT = 4'h0;
	localparam logic [7:0] MASK_MODE = 8'h3f;
	localparam logic [7:0] MASK_LVL_TIMING = 8'h3f;
	localparam logic [7:0] MASK_SHUTDOWN = 8'h03;

	// ****************************************************************
	// Field positions.
	// ****************************************************************
	localparam int GAIN_COPY_BIT = 7;
	localparam int GAIN_MUTE_BIT = 6;
	localparam int LVL_ENABLE_BIT = 7;
	localparam int MODE_LEFT_TO_BOTH_BIT = 0;
	localparam int MODE_RIGHT_TO_BOTH_BIT = 1;
	localparam int MODE_OT_RECOVERY_BIT = 2;
	localparam int MODE_OC_RECOVERY_BIT = 3;
	localparam int MODE_EDGE_LSB = 4;
	localparam logic [5:0] GAIN_CODE_MAX = 6'h2e;

	typedef enum {
		ST_IDLE,
		ST_ADDR,
		ST_ACK_A,
		ST_WR_BYTE,
		ST_ACK_W,
		ST_RD_BYTE,
		ST_ACK_R
	} asc_state_t;

endpackage : asc_pkg

// File: src/asc_regs.sv
`timescale 1ns/100ps
// Operation
// - Each access carries a sixteen bit word, most significant bit first.
// - Upper seven word bits address a register; of the lower nine, bits 7:0 carry data and bit 8 is ignored.
// - The port answers bus address 0x31 only.
// - Address byte bit zero picks direction: zero writes, one reads.
// - Gain code 0 gives 1 dB, linear up to 24 dB at 0x2e.
// - Right gain register: copy bit 7, mute bit 6, code bits 5:0.
// - Each gain code step adds half a decibel.
// - Level control on blocks gain writes; left code sets both channels.
// - A set mute bit silences its channel; cleared by default.
// - Mode bit 0 sends left to both outputs, bit 1 sends right.
module asc_regs
	import asc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic serial_clk,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n,
	input wire logic [3:0] fault_in,
	output logic [5:0] left_gain_code,
	output logic [5:0] right_gain_code,
	output logic left_channel_mute,
	output logic right_channel_mute,
	output logic route_left_to_both,
	output logic route_right_to_both,
	output logic [1:0] edge_rate,
	output logic overcurrent_recovery,
	output logic overtemp_recovery,
	output logic [7:0] level_timing,
	output logic [7:0] level_config,
	output logic left_shutdown,
	output logic right_shutdown
);
	import asc_pkg::*;

	// ****************************************************************
	// Link domain: start detection on the data line.
	// ****************************************************************
	logic start_tgl_reg;

	// A start is data falling while the serial clock is high.
	always_ff @(negedge sda_i or posedge rst) begin
		if (rst) begin
			start_tgl_reg <= 1'b0;
		end else if (serial_clk) begin
			start_tgl_reg <= ~start_tgl_reg;
		end
	end

	// ****************************************************************
	// Link domain: receive and transmit engine on the serial clock.
	// ****************************************************************
	asc_state_t state_reg, state_next;
	logic [2:0] bit_cnt_reg, bit_cnt_next;
	logic [7:0] shift_reg, shift_next;
	logic [7:0] hi_byte_reg, hi_byte_next;
	logic byte_idx_reg, byte_idx_next;
	logic [15:0] wr_word_reg, wr_word_next;
	logic wr_tgl_reg, wr_tgl_next;
	logic start_ack_reg, start_ack_next;
	logic rd_hold_reg, rd_hold_next;
	logic rw_reg, rw_next;
	logic [15:0] rd_tx_reg, rd_tx_next;
	logic [15:0] rd_word_reg, rd_word_next;
	logic [7:0] byte_in;

	// Bits are sampled on the rising serial clock edge.
	always_comb begin
		state_next = state_reg;
		bit_cnt_next = bit_cnt_reg + 3'h1;
		shift_next = {shift_reg[6:0], sda_i};
		hi_byte_next = hi_byte_reg;
		byte_idx_next = byte_idx_reg;
		wr_word_next = wr_word_reg;
		wr_tgl_next = wr_tgl_reg;
		start_ack_next = start_ack_reg;
		rd_hold_next = rd_hold_reg;
		rw_next = rw_reg;
		rd_tx_next = rd_tx_reg;
		byte_in = {shift_reg[6:0], sda_i};
		if (start_tgl_reg != start_ack_reg) begin
			start_ack_next = start_tgl_reg;
			state_next = ST_ADDR;
			bit_cnt_next = 3'h1;
			rd_hold_next = 1'b0;
		end else begin
			case (state_reg)
				ST_ADDR: begin
					if (bit_cnt_reg == 3'h7) begin
						rw_next = byte_in[0];
						state_next = (byte_in[7:1] == ASC_BUS_ADDR) ?
							ST_ACK_A : ST_IDLE;
					end
				end
				ST_ACK_A: begin
					bit_cnt_next = 3'h0;
					byte_idx_next = 1'b0;
					if (rw_reg) begin
						state_next = ST_RD_BYTE;
						rd_tx_next = rd_word_reg;
						rd_hold_next = 1'b1;
					end else begin
						state_next = ST_WR_BYTE;
					end
				end
				ST_WR_BYTE: begin
					if (bit_cnt_reg == 3'h7) begin
						state_next = ST_ACK_W;
						if (!byte_idx_reg) begin
							hi_byte_next = byte_in;
						end else begin
							wr_word_next = {hi_byte_reg, byte_in};
							wr_tgl_next = ~wr_tgl_reg;
						end
					end
				end
				ST_ACK_W: begin
					state_next = ST_WR_BYTE;
					bit_cnt_next = 3'h0;
					byte_idx_next = ~byte_idx_reg;
				end
				ST_RD_BYTE: begin
					rd_tx_next = {rd_tx_reg[14:0], 1'b0};
					if (bit_cnt_reg == 3'h7) begin
						state_next = ST_ACK_R;
					end
				end
				ST_ACK_R: begin
					bit_cnt_next = 3'h0;
					state_next = sda_i ? ST_IDLE : ST_RD_BYTE;
					rd_hold_next = ~sda_i;
				end
				default: begin
					bit_cnt_next = bit_cnt_reg;
				end
			endcase
		end
	end

	// The controller owns the clock; nothing here runs between frames.
	always_ff @(posedge serial_clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			bit_cnt_reg <= 3'h0;
			shift_reg <= 8'h00;
			hi_byte_reg <= 8'h00;
			byte_idx_reg <= 1'b0;
			wr_word_reg <= 16'h0000;
			wr_tgl_reg <= 1'b0;
			start_ack_reg <= 1'b0;
			rd_hold_reg <= 1'b0;
			rw_reg <= 1'b0;
			rd_tx_reg <= 16'h0000;
		end else begin
			state_reg <= state_next;
			bit_cnt_reg <= bit_cnt_next;
			shift_reg <= shift_next;
			hi_byte_reg <= hi_byte_next;
			byte_idx_reg <= byte_idx_next;
			wr_word_reg <= wr_word_next;
			wr_tgl_reg <= wr_tgl_next;
			start_ack_reg <= start_ack_next;
			rd_hold_reg <= rd_hold_next;
			rw_reg <= rw_next;
			rd_tx_reg <= rd_tx_next;
		end
	end

	// Data is changed on the falling edge so it is stable at the rise.
	logic oe_n_reg, drive_next;
	always_comb begin
		case (state_reg)
			ST_ACK_A: drive_next = 1'b1;
			ST_ACK_W: drive_next = 1'b1;
			ST_RD_BYTE: drive_next = ~rd_tx_reg[15];
			default: drive_next = 1'b0;
		endcase
	end

	always_ff @(negedge serial_clk or posedge rst) begin
		if (rst) begin
			oe_n_reg <= 1'b1;
		end else begin
			oe_n_reg <= ~drive_next;
		end
	end

	// Open drain: the pin is only ever pulled low.
	assign sda_o = 1'b0;
	assign sda_oe_n = oe_n_reg;

	// ****************************************************************
	// System domain: crossing and register bank.
	// ****************************************************************
	logic [5:0] sync_out;
	logic wr_seen_reg, wr_seen_next;
	logic take;
	logic [6:0] take_addr;
	logic [7:0] take_data;

	asc_sync #(.WIDTH(6)) u_sync (
		.clk(clk),
		.rst(rst),
		.din({fault_in, rd_hold_reg, wr_tgl_reg}),
		.dout(sync_out)
	);

	// The word register is held for a whole byte time after the toggle.
	assign take = sync_out[0] ^ wr_seen_reg;
	assign take_addr = wr_word_reg[ASC_ADDR_MSB:ASC_ADDR_LSB];
	assign take_data = wr_word_reg[ASC_DATA_MSB:0];
	assign wr_seen_next = sync_out[0];

	logic [7:0] lg_reg, lg_next, rg_reg, rg_next, mode_reg, mode_next;
	logic [7:0] lt_reg, lt_next, lc_reg, lc_next, sd_reg, sd_next;
	logic [3:0] flt_reg, flt_next;
	logic [6:0] last_addr_reg, last_addr_next;
	logic alc_on;

	assign alc_on = lc_reg[LVL_ENABLE_BIT];

	// Register writes; a fault present while clearing stays set.
	always_comb begin
		lg_next = lg_reg;
		rg_next = rg_reg;
		mode_next = mode_reg;
		lt_next = lt_reg;
		lc_next = lc_reg;
		sd_next = sd_reg;
		flt_next = flt_reg | sync_out[5:2];
		last_addr_next = last_addr_reg;
		if (take) begin
			last_addr_next = take_addr;
			case (take_addr)
				OFS_LEFT_GAIN: begin
					if (!alc_on) begin
						lg_next = take_data;
						if (take_data[GAIN_COPY_BIT]) begin
							rg_next[5:0] = take_data[5:0];
						end
					end
				end
				OFS_RIGHT_GAIN: begin
					if (!alc_on) begin
						rg_next = take_data;
						if (take_data[GAIN_COPY_BIT]) begin
							lg_next[5:0] = take_data[5:0];
						end
					end
				end
				OFS_MODE: mode_next = take_data & MASK_MODE;
				OFS_LVL_TIMING: lt_next = take_data & MASK_LVL_TIMING;
				OFS_LVL_CONFIG: lc_next = take_data;
				OFS_SHUTDOWN: sd_next = take_data & MASK_SHUTDOWN;
				// Flags are read only; the write just aims the readback.
				OFS_FAULT: last_addr_next = take_addr;
				OFS_FAULT_CLEAR: flt_next = sync_out[5:2];
				OFS_SOFT_RESET: begin
					lg_next = RST_GAIN;
					rg_next = RST_GAIN;
					mode_next = RST_MODE;
					lt_next = RST_LVL_TIMING;
					lc_next = RST_LVL_CONFIG;
					sd_next = RST_SHUTDOWN;
					flt_next = sync_out[5:2];
				end
				default: begin
					last_addr_next = last_addr_reg;
				end
			endcase
		end
	end

	// Readback word: address, a zero bit and the register byte.
	logic [7:0] rd_sel;
	always_comb begin
		case (last_addr_reg)
			OFS_LEFT_GAIN: rd_sel = lg_reg;
			OFS_RIGHT_GAIN: rd_sel = rg_reg;
			OFS_MODE: rd_sel = mode_reg;
			OFS_LVL_TIMING: rd_sel = lt_reg;
			OFS_LVL_CONFIG: rd_sel = lc_reg;
			OFS_SHUTDOWN: rd_sel = sd_reg;
			OFS_FAULT: rd_sel = {4'h0, flt_reg};
			default: rd_sel = 8'h00;
		endcase
		// Frozen while a read runs so the link sees a steady word.
		rd_word_next = sync_out[1] ? rd_word_reg :
			{last_addr_reg, 1'b0, rd_sel};
	end

	// Gain codes above the top step hold the top gain.
	function automatic logic [5:0] clamp_gain(input logic [5:0] code);
		clamp_gain = (code > GAIN_CODE_MAX) ? GAIN_CODE_MAX : code;
	endfunction : clamp_gain

	// Reset loads defaults; the link is held in reset with the bank.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lg_reg <= RST_GAIN;
			rg_reg <= RST_GAIN;
			mode_reg <= RST_MODE;
			lt_reg <= RST_LVL_TIMING;
			lc_reg <= RST_LVL_CONFIG;
			sd_reg <= RST_SHUTDOWN;
			flt_reg <= RST_FAULT;
			last_addr_reg <= 7'h00;
			wr_seen_reg <= 1'b0;
			rd_word_reg <= 16'h0000;
		end else begin
			lg_reg <= lg_next;
			rg_reg <= rg_next;
			mode_reg <= mode_next;
			lt_reg <= lt_next;
			lc_reg <= lc_next;
			sd_reg <= sd_next;
			flt_reg <= flt_next;
			last_addr_reg <= last_addr_next;
			wr_seen_reg <= wr_seen_next;
			rd_word_reg <= rd_word_next;
		end
	end

	// ****************************************************************
	// Registered control outputs to the analog path.
	// ****************************************************************
	logic [5:0] lcode_reg, rcode_reg;
	logic [14:0] ctl_reg, ctl_next;
	logic [7:0] lt_out_reg, lc_out_reg;

	assign ctl_next = {lg_reg[GAIN_MUTE_BIT], rg_reg[GAIN_MUTE_BIT],
		mode_reg[MODE_LEFT_TO_BOTH_BIT], mode_reg[MODE_RIGHT_TO_BOTH_BIT],
		mode_reg[MODE_EDGE_LSB+1 -: 2], mode_reg[MODE_OC_RECOVERY_BIT],
		mode_reg[MODE_OT_RECOVERY_BIT], sd_reg[0], sd_reg[1], 5'h00};

	// With level control on, the left code drives both channels.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lcode_reg <= RST_GAIN[5:0];
			rcode_reg <= RST_GAIN[5:0];
			ctl_reg <= {RST_GAIN[GAIN_MUTE_BIT], RST_GAIN[GAIN_MUTE_BIT],
				RST_MODE[MODE_LEFT_TO_BOTH_BIT],
				RST_MODE[MODE_RIGHT_TO_BOTH_BIT],
				RST_MODE[MODE_EDGE_LSB+1 -: 2],
				RST_MODE[MODE_OC_RECOVERY_BIT],
				RST_MODE[MODE_OT_RECOVERY_BIT], RST_SHUTDOWN[0],
				RST_SHUTDOWN[1], 5'h00};
			lt_out_reg <= RST_LVL_TIMING;
			lc_out_reg <= RST_LVL_CONFIG;
		end else begin
			lcode_reg <= clamp_gain(lg_reg[5:0]);
			rcode_reg <= alc_on ? clamp_gain(lg_reg[5:0]) :
				clamp_gain(rg_reg[5:0]);
			ctl_reg <= ctl_next;
			lt_out_reg <= lt_reg;
			lc_out_reg <= lc_reg;
		end
	end

	assign left_gain_code = lcode_reg;
	assign right_gain_code = rcode_reg;
	assign left_channel_mute = ctl_reg[14];
	assign right_channel_mute = ctl_reg[13];
	assign route_left_to_both = ctl_reg[12];
	assign route_right_to_both = ctl_reg[11];
	assign edge_rate = ctl_reg[10:9];
	assign overcurrent_recovery = ctl_reg[8];
	assign overtemp_recovery = ctl_reg[7];
	assign left_shutdown = ctl_reg[6];
	assign right_shutdown = ctl_reg[5];
	assign level_timing = lt_out_reg;
	assign level_config = lc_out_reg;

	// ****************************************************************
	// Assertions.
	// ****************************************************************
	// Two clock domains here, so every property names its own clock.
	sequence s_gain_write(logic [6:0] a);
		take && take_addr == a && !alc_on;
	endsequence

	// Mapped writes and soft reset move the read pointer; others do not.
	a_word_addr: assert property (
		@(posedge clk) disable iff (rst)
		take |=> last_addr_reg == (($past(take_addr) > OFS_SOFT_RESET) ?
		$past(last_addr_reg) : $past(take_addr)))
		else $error("Address split wrong.");
	a_right_copy: assert property (
		@(posedge clk) disable iff (rst)
		s_gain_write(OFS_RIGHT_GAIN) ##0 take_data[GAIN_COPY_BIT]
		|=> lg_reg[5:0] == $past(take_data[5:0]))
		else $error("Right copy lost.");
	a_alc_lock: assert property (
		@(posedge clk) disable iff (rst)
		take && alc_on && take_addr == OFS_LEFT_GAIN
		|=> lg_reg == $past(lg_reg))
		else $error("Locked gain written.");
	a_alc_both: assert property (
		@(posedge clk) disable iff (rst)
		$past(alc_on) |-> right_gain_code ==
		clamp_gain($past(lg_reg[5:0])))
		else $error("Right code differs.");
	a_gain_clamp: assert property (
		@(posedge clk) disable iff (rst)
		left_gain_code == clamp_gain($past(lg_reg[5:0])))
		else $error("Gain code not clamped.");
	a_gain_step: assert property (
		@(posedge clk) disable iff (rst)
		s_gain_write(OFS_LEFT_GAIN) ##0 take_data[5:0] < GAIN_CODE_MAX
		|-> ##2 left_gain_code == $past(take_data[5:0], 2))
		else $error("Gain step wrong.");
	a_mute_out: assert property (
		@(posedge clk) disable iff (rst)
		s_gain_write(OFS_LEFT_GAIN)
		|-> ##2 left_channel_mute == $past(take_data[GAIN_MUTE_BIT], 2))
		else $error("Mute not applied.");
	a_route_mode: assert property (
		@(posedge clk) disable iff (rst)
		take && take_addr == OFS_MODE |-> ##2
		route_left_to_both == $past(take_data[0], 2) &&
		route_right_to_both == $past(take_data[1], 2))
		else $error("Route not applied.");
	a_soft_reset: assert property (
		@(posedge clk) disable iff (rst)
		take && take_addr == OFS_SOFT_RESET |=> lg_reg == RST_GAIN &&
		mode_reg == RST_MODE && sd_reg == RST_SHUTDOWN)
		else $error("Soft reset missed.");
	a_addr_match: assert property (
		@(posedge serial_clk) disable iff (rst)
		state_reg == ST_ACK_A |-> $past(shift_reg[6:0]) == ASC_BUS_ADDR)
		else $error("Acked a foreign address.");
	a_word_len: assert property (
		@(posedge serial_clk) disable iff (rst)
		$changed(wr_tgl_reg) |-> $past(byte_idx_reg) &&
		$past(bit_cnt_reg) == 3'h7)
		else $error("Word not sixteen bits.");

endmodule : asc_regs

// File: src/asc_sync.sv
`timescale 1ns/100ps
// Two flip-flop synchroniser; the first stage feeds only the second.
module asc_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	initial begin
		if (WIDTH < 1) $error("asc_sync needs a width of one or more.");
	end

	// Both stages reset to zero and shift every edge.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= din;
			sync_reg <= meta_reg;
		end
	end

	assign dout = sync_reg;

endmodule : asc_sync

// File: verification/asc_bus_ctrl.sv
`timescale 1ns/100ps
// ****************************************
// Two-wire bus controller model.
// ****************************************
module asc_bus_ctrl (
	output logic scl,
	output logic sda_drv,
	input wire logic sda_line
);
	// The clock rests high and the data line is released between frames.
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	// One bit: data moves 1 ns after the fall so it never meets a start.
	task automatic bit_io(input logic b, output logic s);
		#1 sda_drv = b;
		#2 scl = 1'b1;
		s = sda_line;
		#3 scl = 1'b0;
	endtask : bit_io

	// A byte goes out most significant bit first, then the ack slot.
	task automatic send8(input logic [7:0] v, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(v[i], s);
		end
		bit_io(1'b1, ack);
	endtask : send8

	// Start: data falls with the clock high, phase offset from clk.
	task automatic start();
		#1.3 sda_drv = 1'b0;
		#3 scl = 1'b0;
	endtask : start

	// Stop: data rises while the clock is high.
	task automatic stop();
		#1 sda_drv = 1'b0;
		#2 scl = 1'b1;
		#3 sda_drv = 1'b1;
	endtask : stop

	// One control word; ok is high only when all three slots were acked.
	task automatic write_word(input logic [6:0] dev, input logic [15:0] w,
		output logic ok);
		logic a0;
		logic a1;
		logic a2;
		start();
		send8({dev, 1'b0}, a0);
		send8(w[15:8], a1);
		send8(w[7:0], a2);
		stop();
		ok = ~(a0 | a1 | a2);
	endtask : write_word

	// Reads sixteen bits, acks the first byte and refuses the second.
	task automatic read_word(output logic [15:0] w);
		logic s;
		start();
		send8({7'h31, 1'b1}, s);
		for (int i = 15; i >= 0; i--) begin
			bit_io(1'b1, w[i]);
			if (i == 8) bit_io(1'b0, s);
		end
		bit_io(1'b1, s);
		stop();
	endtask : read_word
endmodule : asc_bus_ctrl

// File: verification/tb_top.sv
`timescale 1ns/100ps
// ****************************************
// Register bank bench.
// ****************************************
module tb_top;
	import asc_pkg::*;
	logic clk;
	logic rst;
	logic [3:0] fault_in;
	logic scl;
	logic sda_drv;
	logic sda_o;
	logic sda_oe_n;
	wire sda_line;
	wire [37:0] seen;
	logic [7:0] rg [0:8];
	logic [3:0] flt;
	logic [6:0] ptr;
	logic [31:0] x;
	int bad_count;
	int tests_run;
	logic [5:0] codes [6] = '{6'h00, 6'h01, 6'h22, 6'h2d, 6'h2e, 6'h3f};
	logic [15:0] tbl [14] = '{16'h00a5, 16'h03c3, 16'h0401, 16'h0402,
		16'h05ff, 16'h06ff, 16'h0a00, 16'h0afe, 16'h20ff, 16'h0880,
		16'h0011, 16'h027f, 16'h084b, 16'h0cff};

	// Pull-up on the data line; either party may pull it low.
	assign sda_line = sda_drv & (sda_oe_n | sda_o);

	asc_bus_ctrl ctl (.scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));

	asc_regs DUT (.clk(clk), .rst(rst), .serial_clk(scl), .sda_i(sda_line),
		.sda_o(sda_o), .sda_oe_n(sda_oe_n), .fault_in(fault_in),
		.left_gain_code(seen[37:32]), .right_gain_code(seen[31:26]),
		.left_channel_mute(seen[25]), .right_channel_mute(seen[24]),
		.route_left_to_both(seen[23]), .route_right_to_both(seen[22]),
		.edge_rate(seen[21:20]), .overcurrent_recovery(seen[19]),
		.overtemp_recovery(seen[18]), .level_timing(seen[17:10]),
		.level_config(seen[9:2]), .left_shutdown(seen[1]),
		.right_shutdown(seen[0]));

	// System clock, 40 ns period.
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Random source so that the sequence repeats run to run.
	function automatic logic [31:0] xs();
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xs

	task automatic check(input logic [37:0] s, input logic [37:0] e);
		tests_run++;
		if (s !== e) begin
			bad_count++;
			$display("Error at %0t: saw %h expected %h", $time, s, e);
		end
	endtask : check

	task automatic defaults();
		rg[0] = 8'h22;
		rg[1] = 8'h22;
		rg[2] = 8'h0c;
		rg[3] = 8'h2b;
		rg[4] = 8'h4b;
		rg[5] = 8'h03;
		flt = 4'h0;
	endtask : defaults

	// Outputs the model expects; codes above the top step clamp to it.
	function automatic logic [37:0] exp_vec();
		logic [5:0] l;
		logic [5:0] r;
		l = (rg[0][5:0] > 6'h2e) ? 6'h2e : rg[0][5:0];
		r = (rg[1][5:0] > 6'h2e) ? 6'h2e : rg[1][5:0];
		if (rg[4][7]) r = l;
		return {l, r, rg[0][6], rg[1][6], rg[2][0], rg[2][1], rg[2][5:4],
			rg[2][3], rg[2][2], rg[3], rg[4], rg[5][0], rg[5][1]};
	endfunction : exp_vec

	// Model of one accepted word.
	task automatic apply(input logic [6:0] a, input logic [8:0] v);
		// Addresses past the soft reset leave the readback pointer alone.
		if (a <= 7'h08) ptr = a;
		case (a)
			7'h00, 7'h01: if (!rg[4][7]) begin
				rg[a] = v[7:0];
				if (v[7]) rg[a ^ 7'h01][5:0] = v[5:0];
			end
			7'h02, 7'h03: rg[a] = v[7:0] & 8'h3f;
			7'h04: rg[4] = v[7:0];
			7'h05: rg[5] = v[7:0] & 8'h03;
			7'h07: flt = 4'h0;
			7'h08: defaults();
			default: ;
		endcase
	endtask : apply

	// Outputs settle within a few clocks of the take, so ten is ample.
	task automatic wr(input logic [6:0] dev, input logic [6:0] a,
		input logic [8:0] v);
		logic ok;
		ctl.write_word(dev, {a, v}, ok);
		check(38'(ok), 38'(dev == 7'h31));
		if (dev == 7'h31) apply(a, v);
		repeat (10) @(negedge clk);
		check(seen, exp_vec());
	endtask : wr

	task automatic rd();
		logic [15:0] w;
		ctl.read_word(w);
		check(38'(w), 38'({ptr, 1'b0, (ptr == 7'h06) ? {4'h0, flt} :
			(ptr > 7'h05) ? 8'h00 : rg[ptr]}));
		repeat (4) @(negedge clk);
	endtask : rd

	task automatic end_of_test();
		$display("Checks run %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_of_test

	// Cuts a hang short well beyond the expected run of about 40 us.
	initial begin
		#400000;
		bad_count++;
		end_of_test();
	end

	// Main sequence.
	initial begin
		rst = 1'b1;
		fault_in = 4'h0;
		x = 47;
		ptr = 7'h00;
		defaults();
		repeat (8) @(negedge clk);
		check(seen, exp_vec());
		rst = 1'b0;
		@(negedge clk);
		check(seen, exp_vec());
		$display("Test reset defaults done");
		for (int i = 0; i < 6; i++) begin
			wr(7'h31, 7'h00, {3'b000, codes[i]});
			wr(7'h31, 7'h01, {3'b001, ~codes[i]});
			rd();
		end
		$display("Test gain sweep done");
		for (int i = 0; i < 14; i++) begin
			wr(7'h31, tbl[i][15:9], tbl[i][8:0]);
			if (tbl[i][15:9] < 7'h07) rd();
		end
		$display("Test fixed writes done");
		wr(7'h32, 7'h02, 9'h003);
		wr(7'h30, 7'h05, 9'h000);
		$display("Test foreign address done");
		for (int i = 0; i < 12; i++) begin
			wr(7'h31, 7'(xs() % 6), 9'(xs()));
			rd();
		end
		$display("Test random writes done");
		fault_in = 4'(xs()) | 4'h1;
		flt = fault_in;
		repeat (6) @(negedge clk);
		fault_in = 4'h0;
		wr(7'h31, 7'h06, 9'h000);
		rd();
		wr(7'h31, 7'h07, 9'h000);
		wr(7'h31, 7'h06, 9'h000);
		rd();
		wr(7'h31, 7'h00, 9'h17f);
		wr(7'h31, 7'h08, 9'h000);
		wr(7'h31, 7'h06, 9'h000);
		rd();
		$display("Test faults and soft reset done");
		end_of_test();
	end
endmodule : tb_top
